// *** hw/spr_pkg.sv ***
package spr_pkg;
  // register byte addresses
  localparam logic [11:0] SPR_ADDR_CFG_B = 12'h04E;
  localparam logic [11:0] SPR_ADDR_CFG_A = 12'hFE8;
  // reset values
  localparam logic [7:0] SPR_CFG_A_RST = 8'hC3;
  localparam logic [7:0] SPR_CFG_B_RST = 8'h00;
  // cfg_a field positions
  localparam int SPR_A_SUB_OSC = 7;
  localparam int SPR_A_MAIN_OSC = 6;
  localparam int SPR_A_RSV_HI = 5;
  localparam int SPR_A_RSV_LO = 4;
  localparam int SPR_A_CNT_CLK = 3;
  localparam int SPR_A_BUZZ = 2;
  localparam int SPR_A_RST_OE = 1;
  localparam int SPR_A_RST_EN = 0;
  // cfg_b field positions
  localparam int SPR_B_ADC = 7;
  localparam int SPR_B_CMP1 = 6;
  localparam int SPR_B_CMP0 = 5;
  localparam int SPR_B_TW_HI = 4;
  localparam int SPR_B_TW_LO = 3;
  localparam int SPR_B_SERIAL = 2;
  localparam int SPR_B_PULSE = 1;
  localparam int SPR_B_TRIG = 0;
  // writable bits of cfg_a: reserved bits read zero
  localparam logic [7:0] SPR_CFG_A_WMASK = 8'hCF;
  localparam logic [7:0] SPR_ZERO8 = 8'h00;
  // two-wire routing codes
  typedef enum logic [1:0] {
    SPR_TW_OFF = 2'b00,
    SPR_TW_PORT0 = 2'b01,
    SPR_TW_PORT16 = 2'b10,
    SPR_TW_BAD = 2'b11
  } spr_tw_t;
endpackage : spr_pkg

// *** hw/spr_pin_routing.sv ***
// Chosen here: strobed register access.
`timescale 1ns/1ps
// Notes on behaviour
// - cfg_a bit7 zero: port G subclock osc
// - cfg_a bit6 zero: port F main osc
// - count clock from port1.2 or port0.4
// - buzzer on port G.1 or port0.1
// - reset output needs enable and reset input
// - reset input enable zero gives GPIO
// - variant strap forces reset input on
// - reset bits set only on power-on
// - ADC source analog 0-15 or opamp
// - compare0 on port7.0 or port G.1
// - two-wire field routes open-drain pins
// - serial pins port0 or port1/6/7
// - pulse output port G.2 or port7.3
// - pulse trigger port G.1 or alternate
module spr_pin_routing
  import spr_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  // clock and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic power_on_rst,
  input wire logic reset_input_forced,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // clock and reset pins
  output logic sub_osc_pins_on,
  output logic main_osc_pins_on,
  output logic reset_in_on,
  output logic reset_out_on,
  // timer and buzzer
  output logic count_clk_from_port0,
  output logic buzzer_on_port0,
  // analog, compare, pulse
  output logic adc_from_opamp,
  output logic compare1_alt,
  output logic compare0_on_port_g,
  output logic pulse_out_on_port7,
  output logic pulse_trig_alt,
  // serial and two-wire
  output logic serial_alt,
  output logic two_wire_on_port0,
  output logic two_wire_on_port16,
  output logic two_wire_bad_code
);

  typedef struct packed {
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [7:0] rdata;
    logic force_in;
    logic sub_osc;
    logic main_osc;
    logic rst_in;
    logic rst_out;
    logic cnt_clk;
    logic buzz;
    logic adc;
    logic cmp1;
    logic cmp0;
    logic pulse;
    logic trig;
    logic serial;
    logic tw_p0;
    logic tw_p16;
    logic tw_bad;
  } spr_state_t;

  spr_state_t st_q;
  spr_state_t st_d;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ref_a);
    hit = (a == ADDR_W'(ref_a));
  endfunction : hit

  logic [7:0] a_nx;
  logic [7:0] b_nx;
  spr_tw_t tw;

  always_comb
  begin
    st_d = st_q;
    a_nx = st_q.cfg_a;
    b_nx = st_q.cfg_b;
    if (reg_wr && hit(reg_addr, SPR_ADDR_CFG_A))
    begin
      a_nx = reg_wdata & SPR_CFG_A_WMASK;
    end
    if (reg_wr && hit(reg_addr, SPR_ADDR_CFG_B))
    begin
      b_nx = reg_wdata;
    end
    if (power_on_rst)
    begin
      a_nx = SPR_CFG_A_RST;
    end
    if (sys_rst || power_on_rst)
    begin
      b_nx = SPR_CFG_B_RST;
    end
    st_d.cfg_a = a_nx;
    st_d.cfg_b = b_nx;
    // strap caught on clock while in reset
    if (sys_rst || power_on_rst)
    begin
      st_d.force_in = reset_input_forced;
    end
    st_d.rdata = SPR_ZERO8;
    if (reg_rd && hit(reg_addr, SPR_ADDR_CFG_A))
    begin
      st_d.rdata = st_q.cfg_a;
    end
    else if (reg_rd && hit(reg_addr, SPR_ADDR_CFG_B))
    begin
      st_d.rdata = st_q.cfg_b;
    end
    // mux flops follow next stored value
    st_d.sub_osc = ~a_nx[SPR_A_SUB_OSC];
    st_d.main_osc = ~a_nx[SPR_A_MAIN_OSC];
    st_d.rst_in = a_nx[SPR_A_RST_EN] | st_d.force_in;
    st_d.rst_out = a_nx[SPR_A_RST_OE] & st_d.rst_in;
    st_d.cnt_clk = a_nx[SPR_A_CNT_CLK];
    st_d.buzz = a_nx[SPR_A_BUZZ];
    st_d.adc = b_nx[SPR_B_ADC];
    st_d.cmp1 = b_nx[SPR_B_CMP1];
    st_d.cmp0 = b_nx[SPR_B_CMP0];
    st_d.pulse = b_nx[SPR_B_PULSE];
    st_d.trig = b_nx[SPR_B_TRIG];
    st_d.serial = b_nx[SPR_B_SERIAL];
    // two-wire decode; bad code routes nothing
    tw = spr_tw_t'(b_nx[SPR_B_TW_HI:SPR_B_TW_LO]);
    st_d.tw_p0 = 1'b0;
    st_d.tw_p16 = 1'b0;
    st_d.tw_bad = 1'b0;
    unique case (tw)
      SPR_TW_OFF:
      begin
      end
      SPR_TW_PORT0:
      begin
        st_d.tw_p0 = 1'b1;
      end
      SPR_TW_PORT16:
      begin
        st_d.tw_p16 = 1'b1;
      end
      SPR_TW_BAD:
      begin
        st_d.tw_bad = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    st_q <= st_d;
  end

  // outputs straight from flops
  assign reg_rdata = st_q.rdata;
  assign sub_osc_pins_on = st_q.sub_osc;
  assign main_osc_pins_on = st_q.main_osc;
  assign reset_in_on = st_q.rst_in;
  assign reset_out_on = st_q.rst_out;
  assign count_clk_from_port0 = st_q.cnt_clk;
  assign buzzer_on_port0 = st_q.buzz;
  assign adc_from_opamp = st_q.adc;
  assign compare1_alt = st_q.cmp1;
  assign compare0_on_port_g = st_q.cmp0;
  assign pulse_out_on_port7 = st_q.pulse;
  assign pulse_trig_alt = st_q.trig;
  assign serial_alt = st_q.serial;
  assign two_wire_on_port0 = st_q.tw_p0;
  assign two_wire_on_port16 = st_q.tw_p16;
  assign two_wire_bad_code = st_q.tw_bad;

endmodule : spr_pin_routing

// *** tb/spr_pin_routing_properties.sv ***
`timescale 1ns/1ps
module spr_pin_routing_props
  import spr_pkg::*;
(
  // clock, resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic power_on_rst,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // routing
  input wire logic sub_osc_pins_on,
  input wire logic reset_in_on,
  input wire logic reset_out_on,
  input wire logic adc_from_opamp,
  input wire logic two_wire_on_port0
);
  logic wa;
  logic wb;
  assign wa = reg_wr && reg_addr == SPR_ADDR_CFG_A;
  assign wb = reg_wr && reg_addr == SPR_ADDR_CFG_B;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst || power_on_rst);
  sub_osc_a: assert property (wa |=> sub_osc_pins_on == !$past(reg_wdata[7]))
    else $error("sub osc");
  rst_out_gate_a: assert property (reset_out_on |-> reset_in_on)
    else $error("reset out");
  rsv_read_a: assert property (reg_rd && reg_addr == SPR_ADDR_CFG_A |=> reg_rdata[5:4] == 2'h0)
    else $error("reserved");
  rst_in_a: assert property (wa && reg_wdata[0] |=> reset_in_on)
    else $error("reset in");
  adc_sel_a: assert property (wb |=> adc_from_opamp == $past(reg_wdata[7]))
    else $error("adc");
  two_wire_a: assert property (wb |=> two_wire_on_port0 == ($past(reg_wdata[4:3]) == 2'h1))
    else $error("two wire");
  por_only_a: assert property (disable iff (power_on_rst) sys_rst |=> $stable({reset_in_on, reset_out_on}))
    else $error("reset bits");
  b_clear_a: assert property (disable iff (power_on_rst) sys_rst |=> !adc_from_opamp && !two_wire_on_port0)
    else $error("cfg b");
endmodule : spr_pin_routing_props

bind spr_pin_routing spr_pin_routing_props u_props (.*);

// *** tb/spr_pin_routing_tb.sv ***
`timescale 1ns/1ps
module spr_pin_routing_tb;
  logic clk, sys_rst, power_on_rst, reset_input_forced, reg_wr, reg_rd;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, got;
  logic sub_osc_pins_on, main_osc_pins_on, reset_in_on, reset_out_on, count_clk_from_port0, buzzer_on_port0;
  logic adc_from_opamp, compare1_alt, compare0_on_port_g, pulse_out_on_port7, pulse_trig_alt, serial_alt;
  logic two_wire_on_port0, two_wire_on_port16, two_wire_bad_code;
  int miscompares = 0, num_checks = 0;
  wire logic [7:0] ra = {~sub_osc_pins_on, ~main_osc_pins_on, 2'h0, count_clk_from_port0, buzzer_on_port0,
    reset_out_on, reset_in_on};
  wire logic [7:0] rb = {adc_from_opamp, compare1_alt, compare0_on_port_g, two_wire_on_port16, two_wire_on_port0,
    serial_alt, pulse_out_on_port7, pulse_trig_alt};
  spr_pin_routing u_spr_pin_routing (.*);
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
    #1;
  endtask : wr
  task rd(input logic [11:0] a);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 got = reg_rdata;
  endtask : rd
  task t_por;
    rd(12'hFE8);
    chk("cfg_a", 8'hC3, got);
    rd(12'h04E);
    chk("cfg_b", 8'h00, got);
    chk("pins_a", 8'hC3, ra);
  endtask : t_por
  task t_cfg_a;
    // timer count input enabled by software elsewhere
    wr(12'hFE8, 8'hCF);
    chk("pins_a", 8'hCF, ra);
    rd(12'hFE8);
    chk("cfg_a", 8'hCF, got);
    // port F line2 data taken as set before this
    wr(12'hFE8, 8'h02);
    chk("pins_a", 8'h00, ra);
  endtask : t_cfg_a
  task t_cfg_b;
    for (int i = 0; i < 8; i++)
    begin
      wr(12'h04E, 8'h01 << i);
      chk("pins_b", 8'h01 << i, rb);
    end
    wr(12'h04E, 8'h18);
    chk("bad_code", 8'h01, {5'h0, rb[4:3], two_wire_bad_code});
    wr(12'h04F, 8'hFF);
    rd(12'h04F);
    chk("unmapped", 8'h00, got | rb);
  endtask : t_cfg_b
  task t_sys_rst;
    wr(12'h04E, 8'hE7);
    wr(12'hFE8, 8'h0D);
    @(posedge clk);
    sys_rst <= 1'h1;
    @(posedge clk);
    sys_rst <= 1'h0;
    #1;
    chk("pins_b", 8'h00, rb);
    chk("pins_a", 8'h0D, ra);
    @(posedge clk);
    sys_rst <= 1'h1;
    reset_input_forced <= 1'h1;
    @(posedge clk);
    sys_rst <= 1'h0;
    // port F line2 data taken as set before this
    wr(12'hFE8, 8'h00);
    chk("strap", 8'h01, {7'h0, reset_in_on});
  endtask : t_sys_rst
  initial
  begin
    repeat (500) @(posedge clk);
    miscompares++;
    close_out;
  end
  initial
  begin
    {sys_rst, power_on_rst, reset_input_forced, reg_wr, reg_rd} = 5'h18;
    {reg_addr, reg_wdata} = 20'h0;
    repeat (3) @(posedge clk);
    {sys_rst, power_on_rst} <= 2'h0;
    t_por;
    t_cfg_a;
    t_cfg_b;
    t_sys_rst;
    close_out;
  end
endmodule : spr_pin_routing_tb
